// >>> main_nco_control.sv
// Main datapath oscillator control registers, paged per converter path,
// with the tuning-word load sequencer. Assumes the register port comes
// from logic on clock_i, so it is not synchronised.
// Functional notes
// - Modulator enable bit 3 turns main modulation on; resets to 0.
// - Fractional modulus extension used only while bit 2 is 1; reset 0.
// - Sideband bit 1: 0 upper sideband, 1 lower, spectrally inverted.
// - Follow-main 0: channel oscillators load on their own requests.
// - Follow-main 1, the reset value: channel loads follow main loads.
// - Each control field exists per path; page bits choose the copy.
// - Auto-request field 000, reset value, raises no load on byte writes.
// - Field 001..110 raises load after byte value-minus-one is written.
// - Writing 0-to-1 on load request bit loads; writing 0 clears ack.
// - Load acknowledge reads 1 once the tuning word has been loaded.
// - 48-bit tuning word in bytes 0x114..0x119, least significant first.
`timescale 1ns/1ns
`include "nco_ctrl_consts.svh"
module main_nco_control (
  input wire logic clock_i,                   // System clock, 20 MHz
  input wire logic arst_n_i,                  // Async reset, active low
  input wire logic [11:0] reg_addr_i,         // Register address
  input wire logic reg_wr_i,                  // Write strobe
  input wire logic [7:0] reg_wdata_i,         // Write data
  input wire logic reg_rd_i,                  // Read strobe
  input wire logic [1:0] chan_update_req_i,   // Channel update requests
  output logic [7:0] reg_rdata_o,             // Read data
  output logic reg_rvalid_o,                  // Read data valid pulse
  output logic [1:0] modulator_enable_o,      // Modulation on, per path
  output logic [1:0] fractional_modulus_enable_o, // Modulus on
  output logic [1:0] sideband_select_o,       // 1 = lower sideband
  output logic [1:0] channel_osc_follow_main_o, // Channel follow main
  output logic [3:0] datapath_mode_o,         // Switch mode, 2 bits/path
  output logic [1:0] sysref_load_arm_o,       // Sysref load arm bit
  output logic [95:0] tuning_word_o,          // Active words, 48 bits/path
  output logic [1:0] main_load_o,             // Main load pulse per path
  output logic [1:0] chan_osc_load_o          // Channel load pulse
);
  tw_mem_if mem ();

  tw_byte_store u_store (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .mem(mem)
  );

  logic [1:0] page_q, page_d;
  logic [7:0] cfg_w [`NPATH];
  logic [7:0] upd_w [`NPATH];
  logic [1:0] pend_w;
  logic wr_page, wr_cfg, wr_upd, wr_ftw, rd_ftw, rd_path;
  logic [11:0] ftw_off;
  logic [2:0] ftw_byte;
  logic [1:0] taken, done;
  nco_ctrl_pkg::load_state_t state_q, state_d;
  logic [2:0] idx_q, idx_d;
  logic path_q, path_d;
  logic [47:0] shadow_q, shadow_d;
  logic rd1_q, rd1_d, rpath1_q, rpath1_d;
  logic [11:0] addr1_q, addr1_d;
  logic [7:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;

  // Address decode of the register port
  always_comb begin
    ftw_off = reg_addr_i - `FTW0_ADDR;
    ftw_byte = ftw_off[2:0];
    wr_page = reg_wr_i && (reg_addr_i == `PAGE_ADDR);
    wr_cfg = reg_wr_i && (reg_addr_i == `CFG_ADDR);
    wr_upd = reg_wr_i && (reg_addr_i == `UPD_ADDR);
    rd_ftw = (reg_addr_i >= `FTW0_ADDR) && (reg_addr_i <= `FTW5_ADDR);
    wr_ftw = reg_wr_i && rd_ftw;
    rd_path = !page_q[0] && page_q[1];
  end

  // Page select register
  always_comb begin
    page_d = page_q;
    if (wr_page) begin
      page_d = reg_wdata_i[1:0];
    end
  end
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      page_q <= `PAGE_RST;
    end else begin
      page_q <= page_d;
    end
  end

  assign mem.we = {2{wr_ftw}} & page_q;
  assign mem.wbyte = ftw_byte;
  assign mem.wdata = reg_wdata_i;

  // Per-path control copies
  for (genvar p = 0; p < `NPATH; p++) begin : g_path
    logic [7:0] cfg_q, cfg_d;
    logic [2:0] mode_q, mode_d;
    logic arm_q, arm_d, req_q, req_d, ack_q, ack_d, pend_q, pend_d;
    logic [47:0] word_q, word_d;
    logic load_q, load_d, chan_q, chan_d, sel, trig;
    always_comb begin
      cfg_d = cfg_q;
      mode_d = mode_q;
      arm_d = arm_q;
      req_d = req_q;
      ack_d = ack_q;
      pend_d = pend_q;
      word_d = word_q;
      sel = page_q[p];
      trig = 1'b0;
      if (wr_cfg && sel) begin
        cfg_d = reg_wdata_i & `CFG_WMASK;
      end
      if (wr_upd && sel) begin
        mode_d = reg_wdata_i[`UPD_MODE_LSB +: 3];
        arm_d = reg_wdata_i[`UPD_SYSREF];
        req_d = reg_wdata_i[`UPD_REQ];
        if (reg_wdata_i[`UPD_REQ] && !req_q) begin
          trig = 1'b1;
        end
        if (!reg_wdata_i[`UPD_REQ]) begin
          ack_d = 1'b0;
        end
      end
      if (wr_ftw && sel && (mode_q != `MODE_NONE) &&
          (mode_q != `MODE_UNUSED) && (ftw_byte == mode_q - 3'h1)) begin
        trig = 1'b1;
      end
      if (trig) begin
        ack_d = 1'b0;
      end
      if (taken[p]) begin
        pend_d = 1'b0;
      end
      if (trig) begin
        pend_d = 1'b1;
      end
      if (done[p]) begin
        ack_d = 1'b1;
        word_d = shadow_q;
      end
      load_d = done[p];
      chan_d = cfg_q[`CFG_FOLLOW] ? load_q : chan_update_req_i[p];
    end
    always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        cfg_q <= `CFG_RST;
        mode_q <= `MODE_RST;
        arm_q <= 1'b0;
        req_q <= 1'b0;
        ack_q <= 1'b0;
        pend_q <= 1'b0;
        word_q <= 48'h0;
        load_q <= 1'b0;
        chan_q <= 1'b0;
      end else begin
        cfg_q <= cfg_d;
        mode_q <= mode_d;
        arm_q <= arm_d;
        req_q <= req_d;
        ack_q <= ack_d;
        pend_q <= pend_d;
        word_q <= word_d;
        load_q <= load_d;
        chan_q <= chan_d;
      end
    end
    assign cfg_w[p] = cfg_q;
    assign upd_w[p] = {1'b0, mode_q, 1'b0, arm_q, ack_q, req_q};
    assign pend_w[p] = pend_q;
    assign modulator_enable_o[p] = cfg_q[`CFG_MOD_EN];
    assign fractional_modulus_enable_o[p] = cfg_q[`CFG_MODULUS_EN];
    assign sideband_select_o[p] = cfg_q[`CFG_SIDEBAND];
    assign channel_osc_follow_main_o[p] = cfg_q[`CFG_FOLLOW];
    assign datapath_mode_o[2*p +: 2] = cfg_q[`CFG_MODE_LSB +: 2];
    assign sysref_load_arm_o[p] = arm_q;
    assign tuning_word_o[48*p +: 48] = word_q;
    assign main_load_o[p] = load_q;
    assign chan_osc_load_o[p] = chan_q;
  end

  // Store read address: bus reads first, sequencer otherwise
  always_comb begin
    if (reg_rd_i) begin
      mem.raddr = rd_path ? (4'(ftw_byte) + 4'h6) : {1'b0, ftw_byte};
    end else begin
      mem.raddr = path_q ? (4'(idx_q) + 4'h6) : {1'b0, idx_q};
    end
  end

  // Load sequencer: gathers six bytes, then swaps in the new word
  always_comb begin
    state_d = state_q;
    idx_d = idx_q;
    path_d = path_q;
    shadow_d = shadow_q;
    taken = 2'b00;
    done = 2'b00;
    case (state_q)
      nco_ctrl_pkg::LD_IDLE: begin
        if (|pend_w) begin
          path_d = !pend_w[0];
          taken = pend_w[0] ? 2'b01 : 2'b10;
          idx_d = 3'h0;
          state_d = nco_ctrl_pkg::LD_ISSUE;
        end
      end
      nco_ctrl_pkg::LD_ISSUE: begin
        if (!reg_rd_i) begin
          state_d = nco_ctrl_pkg::LD_CAPTURE;
        end
      end
      nco_ctrl_pkg::LD_CAPTURE: begin
        shadow_d[{idx_q, 3'b000} +: 8] = mem.rdata;
        if (idx_q == `LAST_BYTE) begin
          state_d = nco_ctrl_pkg::LD_FINISH;
        end else begin
          idx_d = idx_q + 3'h1;
          state_d = nco_ctrl_pkg::LD_ISSUE;
        end
      end
      nco_ctrl_pkg::LD_FINISH: begin
        done = path_q ? 2'b10 : 2'b01;
        state_d = nco_ctrl_pkg::LD_IDLE;
      end
      default: begin
        state_d = nco_ctrl_pkg::LD_IDLE;
      end
    endcase
  end
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= nco_ctrl_pkg::LD_IDLE;
      idx_q <= 3'h0;
      path_q <= 1'b0;
      shadow_q <= 48'h0;
    end else begin
      state_q <= state_d;
      idx_q <= idx_d;
      path_q <= path_d;
      shadow_q <= shadow_d;
    end
  end

  // Two-stage read: address capture, then data select
  always_comb begin
    rd1_d = reg_rd_i;
    addr1_d = reg_addr_i;
    rpath1_d = rd_path;
    rvalid_d = rd1_q;
    rdata_d = rdata_q;
    if (rd1_q) begin
      if (addr1_q == `PAGE_ADDR) begin
        rdata_d = {6'h00, page_q};
      end else if (addr1_q == `CFG_ADDR) begin
        rdata_d = cfg_w[rpath1_q];
      end else if (addr1_q == `UPD_ADDR) begin
        rdata_d = upd_w[rpath1_q];
      end else if ((addr1_q >= `FTW0_ADDR) && (addr1_q <= `FTW5_ADDR)) begin
        rdata_d = mem.rdata;
      end else begin
        rdata_d = 8'h00;
      end
    end
  end
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd1_q <= 1'b0;
      addr1_q <= 12'h000;
      rpath1_q <= 1'b0;
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rd1_q <= rd1_d;
      addr1_q <= addr1_d;
      rpath1_q <= rpath1_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end
  assign reg_rdata_o = rdata_q;
  assign reg_rvalid_o = rvalid_q;
endmodule

// >>> nco_ctrl_consts.svh
// Offsets, field positions, reset values and sizes of the main oscillator
// control registers. Included by the design, checker and bench files.
`ifndef NCO_CTRL_CONSTS_SVH
`define NCO_CTRL_CONSTS_SVH

`define ADDR_W 12
`define NPATH 2
`define FTW_BYTES 6
`define TW_ENTRIES 12
`define TW_IDX_W 4

`define PAGE_ADDR 12'h008
`define CFG_ADDR 12'h112
`define UPD_ADDR 12'h113
`define FTW0_ADDR 12'h114
`define FTW5_ADDR 12'h119

`define PAGE_RST 2'h3
`define CFG_RST 8'h01
`define CFG_WMASK 8'h3f
`define CFG_MODE_LSB 4
`define CFG_MOD_EN 3
`define CFG_MODULUS_EN 2
`define CFG_SIDEBAND 1
`define CFG_FOLLOW 0

`define UPD_MODE_LSB 4
`define UPD_SYSREF 2
`define UPD_ACK 1
`define UPD_REQ 0
`define MODE_RST 3'h0
`define MODE_NONE 3'h0
`define MODE_UNUSED 3'h7
`define LAST_BYTE 3'h5

`endif

// >>> nco_ctrl_pkg.sv
// Types shared by the main oscillator control files.
// Assumes the constants header is available on the include path.
package nco_ctrl_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [1:0] {
    LD_IDLE,
    LD_ISSUE,
    LD_CAPTURE,
    LD_FINISH
  } load_state_t;
endpackage

// >>> tw_mem_if.sv
// Port group between the control logic and the tuning-word byte store.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface tw_mem_if;
  logic [1:0] we;
  logic [2:0] wbyte;
  logic [7:0] wdata;
  logic [3:0] raddr;
  logic [7:0] rdata;
  modport ctrl (output we, output wbyte, output wdata, output raddr,
                input rdata);
  modport store (input we, input wbyte, input wdata, input raddr,
                 output rdata);
endinterface

// >>> tw_byte_store.sv
// Tuning-word byte store: six bytes per converter path, read data from a
// register. Assumes a single clock and the async low reset of its user.
`timescale 1ns/1ns
`include "nco_ctrl_consts.svh"
module tw_byte_store (
  input wire logic clock_i,  // System clock
  input wire logic arst_n_i, // Async reset, active low
  tw_mem_if.store mem        // Write and read port
);
  logic [7:0] ent_w [`TW_ENTRIES];
  logic [7:0] rdata_q, rdata_d;

  // One byte per entry, written on every selected path at once
  for (genvar i = 0; i < `TW_ENTRIES; i++) begin : g_ent
    localparam int P = i / `FTW_BYTES;
    localparam logic [2:0] B = 3'(i % `FTW_BYTES);
    logic [7:0] q, d;
    always_comb begin
      d = q;
      if (mem.we[P] && (mem.wbyte == B)) begin
        d = mem.wdata;
      end
    end
    always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        q <= 8'h00;
      end else begin
        q <= d;
      end
    end
    assign ent_w[i] = q;
  end

  // Registered read port
  always_comb begin
    rdata_d = 8'h00;
    if (mem.raddr < 4'(`TW_ENTRIES)) begin
      rdata_d = ent_w[mem.raddr];
    end
  end
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end
  assign mem.rdata = rdata_q;
endmodule

// >>> nco_ctrl_chk.sv
// Checker for the main oscillator control block, bound to its ports.
// Assumes one clock domain and the async low reset of the block.
`timescale 1ns/1ns
`include "nco_ctrl_consts.svh"
module nco_ctrl_chk (
  input wire logic clock_i, // Clock
  input wire logic arst_n_i, // Reset
  input wire logic [11:0] reg_addr_i, // Address
  input wire logic reg_wr_i, // Write
  input wire logic [7:0] reg_wdata_i, // Data
  input wire logic reg_rd_i, // Read
  input wire logic [1:0] chan_update_req_i, // Channel req
  input wire logic reg_rvalid_o, // Read valid
  input wire logic [1:0] modulator_enable_o, // Mod on
  input wire logic [1:0] sideband_select_o, // Sideband
  input wire logic [1:0] channel_osc_follow_main_o, // Follow
  input wire logic [95:0] tuning_word_o, // Words
  input wire logic [1:0] main_load_o, // Main load
  input wire logic [1:0] chan_osc_load_o // Channel load
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  logic [1:0] page_q, page_d;
  logic cfg_wr;
  // Shadow of the page bits
  always_comb begin
    cfg_wr = reg_wr_i && reg_addr_i == `CFG_ADDR;
    page_d = page_q;
    if (reg_wr_i && reg_addr_i == `PAGE_ADDR) begin
      page_d = reg_wdata_i[1:0];
    end
  end
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) page_q <= `PAGE_RST;
    else page_q <= page_d;
  end
  AST_MOD_WR: assert property (cfg_wr && page_q[0] |=>
    modulator_enable_o[0] == $past(reg_wdata_i[3])) else $error("mod bit");
  AST_SB_WR: assert property (cfg_wr && page_q[1] |=>
    sideband_select_o[1] == $past(reg_wdata_i[1])) else $error("sideband");
  AST_NO_PAGE: assert property (cfg_wr && page_q == 2'h0 |=>
    $stable(modulator_enable_o)) else $error("unpaged write kept");
  AST_ONE_PATH: assert property (main_load_o != 2'h3)
    else $error("both paths load");
  AST_RD_ANS: assert property (reg_rd_i |-> ##2 reg_rvalid_o)
    else $error("read answer late");
  AST_CH_FOLLOW: assert property (main_load_o[0] &&
    channel_osc_follow_main_o[0] |=> chan_osc_load_o[0])
    else $error("channel load missed");
  AST_CH_OWN: assert property (!channel_osc_follow_main_o[0] |=>
    chan_osc_load_o[0] == $past(chan_update_req_i[0]))
    else $error("own request");
  AST_WORD_CHG: assert property ($changed(tuning_word_o[47:0])
    |-> main_load_o[0]) else $error("word moved alone");
  AST_LOAD_GAP: assert property (main_load_o[0] |=>
    !main_load_o[0] [*8]) else $error("load too soon");
endmodule
bind main_nco_control nco_ctrl_chk u_chk (.clock_i(clock_i),
  .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
  .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
  .chan_update_req_i(chan_update_req_i), .reg_rvalid_o(reg_rvalid_o),
  .modulator_enable_o(modulator_enable_o),
  .sideband_select_o(sideband_select_o),
  .channel_osc_follow_main_o(channel_osc_follow_main_o),
  .tuning_word_o(tuning_word_o), .main_load_o(main_load_o),
  .chan_osc_load_o(chan_osc_load_o));

// >>> main_nco_control_and_ftw_update_bench.sv
// Register level bench for the main oscillator control block.
// Assumes the checker is bound to the design from its own file.
`timescale 1ns/1ns
`include "nco_ctrl_consts.svh"
module main_nco_control_and_ftw_update_bench;
  logic clock_i = 0, arst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0;
  logic [11:0] reg_addr_i = 0;
  logic [7:0] reg_wdata_i = 0, reg_rdata_o;
  logic [1:0] chan_update_req_i = 0, modulator_enable_o;
  logic [1:0] fractional_modulus_enable_o, sideband_select_o;
  logic [1:0] channel_osc_follow_main_o, sysref_load_arm_o;
  logic [1:0] main_load_o, chan_osc_load_o;
  logic reg_rvalid_o;
  logic [3:0] datapath_mode_o;
  logic [95:0] tuning_word_o;
  logic [47:0] exp_w;
  int miscompares = 0, checks = 0, nload = 0, n0, b;
  main_nco_control dut (.*);
  // Clock and load counter
  always #25 clock_i = ~clock_i;
  always @(posedge clock_i) if (main_load_o[0] === 1'b1) nload++;
  task chk(input logic [63:0] s, input logic [63:0] e);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clock_i); #5;
    reg_wr_i = 1; reg_addr_i = a; reg_wdata_i = d;
    @(posedge clock_i); #5;
    reg_wr_i = 0;
  endtask
  task rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge clock_i); #5;
    reg_rd_i = 1; reg_addr_i = a;
    @(posedge clock_i); #5;
    reg_rd_i = 0;
    @(posedge clock_i); #1;
    chk(reg_rvalid_o, 1);
    chk(reg_rdata_o, e);
  endtask
  task report_and_stop;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    #200000;
    miscompares++;
    report_and_stop;
  end
  initial begin
    repeat (8) @(posedge clock_i);
    #5 arst_n_i = 1;
    chk(channel_osc_follow_main_o, 2'h3);
    chk(modulator_enable_o, 2'h0);
    rd(`PAGE_ADDR, 8'h03);
    rd(`CFG_ADDR, 8'h01);
    rd(`UPD_ADDR, 8'h00);
    rd(12'h111, 8'h00);
    $display("reset test done");
    wr(`PAGE_ADDR, 8'h01);
    // Software enables modulation on the path in use
    wr(`CFG_ADDR, 8'h0e);
    wr(`PAGE_ADDR, 8'h02);
    wr(`CFG_ADDR, 8'h03);
    wr(`PAGE_ADDR, 8'h00);
    wr(`CFG_ADDR, 8'hff);
    chk(modulator_enable_o, 2'h1);
    chk(fractional_modulus_enable_o, 2'h1);
    chk(sideband_select_o, 2'h3);
    chk(channel_osc_follow_main_o, 2'h2);
    @(posedge clock_i); #5 chan_update_req_i = 2'h3;
    @(posedge clock_i); #1;
    chk(chan_osc_load_o, 2'h1);
    #4 chan_update_req_i = 2'h0;
    // Page 0 reads path 0, page 2 reads path 1
    rd(`CFG_ADDR, 8'h0e);
    wr(`PAGE_ADDR, 8'h02);
    rd(`CFG_ADDR, 8'h03);
    wr(`PAGE_ADDR, 8'h01);
    wr(`CFG_ADDR, 8'hff);
    rd(`CFG_ADDR, 8'h3f);
    chk(datapath_mode_o, 4'h3);
    $display("paging test done");
    for (int k = 0; k < 6; k++) begin
      wr(`FTW0_ADDR + 12'(k), 8'h10 + 8'(k));
    end
    wr(`UPD_ADDR, 8'hff);
    repeat (16) @(posedge clock_i); #1;
    chk(tuning_word_o[47:0], 48'h151413121110);
    chk(tuning_word_o[95:48], 48'h0);
    chk(sysref_load_arm_o, 2'h1);
    rd(`FTW0_ADDR + 12'h002, 8'h12);
    rd(`UPD_ADDR, 8'h77);
    wr(`UPD_ADDR, 8'h00);
    rd(`UPD_ADDR, 8'h00);
    $display("load test done");
    exp_w = 48'h151413121110;
    for (int m = 0; m < 8; m++) begin
      n0 = nload;
      b = (m == 0) ? 0 : (m == 7) ? 5 : m - 1;
      wr(`UPD_ADDR, {1'b0, 3'(m), 4'h0});
      wr(`FTW0_ADDR + 12'(b), 8'h20 + 8'(m));
      exp_w[8*b +: 8] = 8'h20 + 8'(m);
      repeat (20) @(posedge clock_i); #1;
      chk(nload - n0, (m > 0 && m < 7));
      if (m > 0 && m < 7) chk(tuning_word_o[47:0], exp_w);
    end
    $display("auto mode test done");
    // Zero word with modulation left on: no shift wanted
    for (int k = 0; k < 6; k++) begin
      wr(`FTW0_ADDR + 12'(k), 8'h00);
    end
    wr(`UPD_ADDR, 8'h01);
    repeat (14) @(posedge clock_i); #1;
    chk(main_load_o, 2'h1);
    chk(tuning_word_o[47:0], 48'h0);
    chk(modulator_enable_o[0], 1'b1);
    @(posedge clock_i); #1;
    chk(chan_osc_load_o, 2'h1);
    chk(main_load_o, 2'h0);
    rd(`UPD_ADDR, 8'h03);
    $display("zero word test done");
    report_and_stop;
  end
endmodule
